// [core/fld_ctrl.sv]
`timescale 1ns/1ns
module fld_ctrl import fld_pkg::*; #(
  parameter int STEP_CYCLES = FLD_STEP_CYC
) (
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_O,
  input  wire logic       STROBE_I,
  input  wire logic       OVP_I,
  input  wire logic       LED_SHORT_I,
  input  wire logic       OVERTEMP_I,
  input  wire logic       BOOST_INDUCTOR_OPEN_I,
  output logic            LED_EN_O,
  output logic            BOOST_EN_O,
  output logic [1:0]      LED_LEVEL_O,
  output logic [7:0]      CURRENT_SET_O
);
  typedef enum logic [1:0] {FLD_PH_OFF, FLD_PH_ARMED, FLD_PH_FLASH} fld_phase_e;

  typedef struct packed {
    logic       strb_m;
    logic       strb;
    logic       strb_p;
    logic [3:0] flt_m;
    logic [3:0] flt;
    logic [7:0] cur;
    logic [7:0] ctl;
    logic [7:0] fault;
    logic       unlock;
    fld_phase_e ph;
    logic [24:0] cnt;
    logic       led_on;
    logic       boost_on;
    logic [1:0] level;
  } fld_ctrl_s;

  fld_ctrl_s  s;
  fld_ctrl_s  next_s;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       fault_ev;
  logic       strb_rise;
  logic       ctl_ok;

  function automatic logic [24:0] fld_len(input logic [3:0] t);
    return 25'((32'(t) + 32'd1) * STEP_CYCLES);
  endfunction

  fld_i2c_slave u_i2c (
    .clk_i    (CLK_I),
    .rst_i    (RST_I),
    .scl_i    (SCL_I),
    .sda_i    (SDA_I),
    .rdata_i  (rdata),
    .sda_oe_o (SDA_OE_O),
    .wr_o     (wr),
    .rd_o     (rd),
    .addr_o   (addr),
    .wdata_o  (wdata)
  );

  assign SDA_O = 1'b0;

  // Faults only count while the output stage is live
  assign fault_ev  = s.led_on & (|s.flt);
  assign strb_rise = s.strb & ~s.strb_p;
  assign ctl_ok = s.unlock |
                  (!wdata[FLD_CTL_STRB] && wdata[FLD_CTL_MODE+:2] != FLD_MODE_IND);

  assign rdata = (addr == FLD_ADR_ID)  ? FLD_ID_VAL  :
                 (addr == FLD_ADR_VER) ? FLD_VER_VAL :
                 (addr == FLD_ADR_CUR) ? s.cur       :
                 (addr == FLD_ADR_CTL) ? s.ctl       :
                 (addr == FLD_ADR_FLT) ? s.fault     : 8'h00;

  always_comb begin
    next_s        = s;
    next_s.strb_m = STROBE_I;
    next_s.strb   = s.strb_m;
    next_s.strb_p = s.strb;
    next_s.flt_m  = {OVP_I, LED_SHORT_I, OVERTEMP_I, BOOST_INDUCTOR_OPEN_I};
    next_s.flt    = s.flt_m;
    case (s.ph)
      FLD_PH_FLASH: begin
        if (s.cnt <= 25'd1) begin
          next_s.ph                   = FLD_PH_OFF;
          next_s.ctl[FLD_CTL_MODE+:2] = FLD_MODE_OFF;
        end else begin
          next_s.cnt = 25'(s.cnt - 25'd1);
        end
      end
      FLD_PH_ARMED: begin
        if (strb_rise) begin
          next_s.ph  = FLD_PH_FLASH;
          next_s.cnt = fld_len(s.ctl[3:0]);
        end
      end
      default: ;
    endcase
    if (wr) begin
      next_s.unlock = 1'b0;
      case (addr)
        FLD_ADR_KEY: next_s.unlock = (wdata == FLD_KEY);
        FLD_ADR_CUR: begin
          if (wdata[1:0] != FLD_CMODE_HI || s.unlock) begin
            next_s.cur = wdata;
          end
        end
        FLD_ADR_CTL: begin
          if (ctl_ok) begin
            next_s.ctl = wdata & FLD_CTL_WMASK;
            next_s.ph  = FLD_PH_OFF;
            if (wdata[FLD_CTL_MODE+:2] == FLD_MODE_FLASH) begin
              if (wdata[FLD_CTL_STRB]) begin
                next_s.ph = FLD_PH_ARMED;
              end else begin
                next_s.ph  = FLD_PH_FLASH;
                next_s.cnt = fld_len(wdata[3:0]);
              end
            end
          end
        end
        default: ;
      endcase
    end
    if (rd && addr == FLD_ADR_FLT) begin
      next_s.fault = FLD_FLT_RST;
    end
    if (fault_ev) begin
      // open LED shows as overvoltage
      // Built on the cleared copy so bits just read do not return
      next_s.fault[FLD_FLT_OVP]  = next_s.fault[FLD_FLT_OVP] | s.flt[3];
      next_s.fault[FLD_FLT_SHRT] = next_s.fault[FLD_FLT_SHRT] | s.flt[2];
      next_s.fault[FLD_FLT_TEMP] = next_s.fault[FLD_FLT_TEMP] | s.flt[1];
      // shut down; coil fault clears mode
      next_s.ctl[FLD_CTL_MODE+:2] = FLD_MODE_OFF;
      next_s.ph                   = FLD_PH_OFF;
    end
    next_s.led_on = (next_s.ph == FLD_PH_FLASH) ||
                    (next_s.ph == FLD_PH_OFF &&
                     (next_s.ctl[FLD_CTL_MODE+:2] == FLD_MODE_IND ||
                      next_s.ctl[FLD_CTL_MODE+:2] == FLD_MODE_ASST));
    // Indicator runs without the boost converter
    next_s.boost_on = next_s.led_on &&
                      (next_s.ctl[FLD_CTL_MODE+:2] != FLD_MODE_IND);
    if (next_s.ph == FLD_PH_FLASH) begin
      next_s.level = FLD_MODE_FLASH;
    end else if (next_s.led_on) begin
      next_s.level = next_s.ctl[FLD_CTL_MODE+:2];
    end else begin
      next_s.level = FLD_MODE_OFF;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s       <= '0;
      s.cur   <= FLD_CUR_RST;
      s.ctl   <= FLD_CTL_RST;
      s.fault <= FLD_FLT_RST;
      s.ph    <= FLD_PH_OFF;
    end else begin
      s <= next_s;
    end
  end

  assign LED_EN_O      = s.led_on;
  assign BOOST_EN_O    = s.boost_on;
  assign LED_LEVEL_O   = s.level;
  assign CURRENT_SET_O = s.cur;

  a_key_single: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    wr && addr != FLD_ADR_KEY |=> !s.unlock)
    else $error("unlock survived a second write");

  a_strobe_locked: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    wr && addr == FLD_ADR_CTL && wdata[FLD_CTL_STRB] && !s.unlock
    |=> s.ctl[FLD_CTL_STRB] == $past(s.ctl[FLD_CTL_STRB]))
    else $error("strobe bit written without unlock");

  a_strobe_arms: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    wr && addr == FLD_ADR_CTL && s.unlock && !fault_ev &&
    wdata[FLD_CTL_STRB] && wdata[FLD_CTL_MODE+:2] == FLD_MODE_FLASH
    |=> s.ph == FLD_PH_ARMED && !LED_EN_O)
    else $error("strobed flash did not wait for strobe");

  a_strobe_fires: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    s.ph == FLD_PH_ARMED && strb_rise && !wr && !fault_ev
    |=> LED_EN_O && s.cnt == fld_len(s.ctl[3:0]))
    else $error("strobe edge did not start timed flash");

  a_flash_start: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    wr && addr == FLD_ADR_CTL && wdata == FLD_CTL_FLASH && !fault_ev
    |=> LED_EN_O && BOOST_EN_O && LED_LEVEL_O == FLD_MODE_FLASH
        && s.cnt == fld_len(4'hF))
    else $error("flash did not start at once with full timer");

  a_flash_end: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    s.ph == FLD_PH_FLASH && s.cnt == 25'd1 && !wr && !fault_ev
    |=> !LED_EN_O && s.ctl[FLD_CTL_MODE+:2] == FLD_MODE_OFF)
    else $error("flash did not return to shutdown");

  a_assist_read: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    wr && addr == FLD_ADR_CTL && wdata == FLD_CTL_ASSIST && !fault_ev
    |=> s.ctl == FLD_CTL_ASSIST && LED_LEVEL_O == FLD_MODE_ASST && LED_EN_O)
    else $error("assist write not reflected");

  a_power_off: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    wr && addr == FLD_ADR_CTL && wdata == FLD_CTL_OFF
    |=> !LED_EN_O && !BOOST_EN_O && s.ph == FLD_PH_OFF)
    else $error("power off write left output on");

  a_fault_off: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    fault_ev |=> !LED_EN_O && !BOOST_EN_O &&
                 s.ctl[FLD_CTL_MODE+:2] == FLD_MODE_OFF)
    else $error("fault did not shut output down");

  a_short_flag: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    fault_ev && s.flt[2] |=> s.fault[FLD_FLT_SHRT])
    else $error("short flag not set");

  a_ovp_flag: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    fault_ev && s.flt[3] |=> s.fault[FLD_FLT_OVP])
    else $error("overvoltage flag not set");

  a_fault_clear: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    rd && addr == FLD_ADR_FLT && !fault_ev |=> s.fault == FLD_FLT_RST)
    else $error("fault register not cleared by read");

  a_fault_rsvd: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    s.fault[4:0] == 5'h00)
    else $error("reserved fault bits set");

  a_high_current: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    wr && addr == FLD_ADR_CUR && wdata == FLD_CUR_MAX && s.unlock
    |=> CURRENT_SET_O == FLD_CUR_MAX)
    else $error("high current write lost");

  a_temp_flag: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    fault_ev && s.flt[1] |=> s.fault[FLD_FLT_TEMP])
    else $error("overtemperature flag not set");

  a_coil_no_flag: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    fault_ev && s.flt == 4'h1 && !rd
    |=> s.ctl[FLD_CTL_MODE+:2] == FLD_MODE_OFF && s.fault == $past(s.fault))
    else $error("coil fault left mode on or set a flag");

  a_key_opens: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    wr && addr == FLD_ADR_KEY && wdata == FLD_KEY |=> s.unlock)
    else $error("key write did not unlock");

  a_indicator_locked: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    wr && addr == FLD_ADR_CTL && !s.unlock &&
    s.ctl[FLD_CTL_MODE+:2] != FLD_MODE_IND
    |=> s.ctl[FLD_CTL_MODE+:2] != FLD_MODE_IND)
    else $error("indicator mode set without unlock");

  a_current_locked: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    wr && addr == FLD_ADR_CUR && wdata[1:0] == FLD_CMODE_HI && !s.unlock
    |=> CURRENT_SET_O == $past(CURRENT_SET_O))
    else $error("high current mode set without unlock");

  a_strobe_stop: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    s.ph != FLD_PH_OFF && wr && addr == FLD_ADR_CTL &&
    !wdata[FLD_CTL_STRB] && wdata[FLD_CTL_MODE+:2] == FLD_MODE_OFF
    |=> s.ph == FLD_PH_OFF && !LED_EN_O)
    else $error("running flash not stopped by control write");
endmodule

// [include/fld_pkg.sv]
package fld_pkg;
  // Register offsets
  localparam logic [7:0] FLD_ADR_ID  = 8'h00;
  localparam logic [7:0] FLD_ADR_VER = 8'h01;
  localparam logic [7:0] FLD_ADR_CUR = 8'h02;
  localparam logic [7:0] FLD_ADR_CTL = 8'h03;
  localparam logic [7:0] FLD_ADR_FLT = 8'h04;
  localparam logic [7:0] FLD_ADR_KEY = 8'h80;
  // Reset values
  localparam logic [7:0] FLD_CUR_RST = 8'hB4;
  localparam logic [7:0] FLD_CTL_RST = 8'h04;
  localparam logic [7:0] FLD_FLT_RST = 8'h00;
  // Identity values, arbitrary
  localparam logic [7:0] FLD_ID_VAL  = 8'h5A;
  localparam logic [7:0] FLD_VER_VAL = 8'h01;
  // Unlock key, known control words and full-scale current value
  localparam logic [7:0] FLD_KEY         = 8'hA1;
  localparam logic [7:0] FLD_CTL_ASSIST  = 8'h20;
  localparam logic [7:0] FLD_CTL_OFF     = 8'h00;
  localparam logic [7:0] FLD_CTL_FLASH   = 8'h3F;
  localparam logic [7:0] FLD_CUR_MAX     = 8'hFF;
  // Reserved control bit reads as zero
  localparam logic [7:0] FLD_CTL_WMASK   = 8'hBF;
  // Field positions
  localparam int FLD_CTL_STRB = 7;
  localparam int FLD_CTL_MODE = 4;
  localparam int FLD_FLT_OVP  = 7;
  localparam int FLD_FLT_SHRT = 6;
  localparam int FLD_FLT_TEMP = 5;
  // Mode field and current_mode field codes
  localparam logic [1:0] FLD_MODE_OFF   = 2'h0;
  localparam logic [1:0] FLD_MODE_IND   = 2'h1;
  localparam logic [1:0] FLD_MODE_ASST  = 2'h2;
  localparam logic [1:0] FLD_MODE_FLASH = 2'h3;
  localparam logic [1:0] FLD_CMODE_HI   = 2'h3;
  // Serial slave address, arbitrary
  localparam logic [6:0] FLD_I2C_ADDR = 7'h30;
  // Flash timer step: 30 ms at 50 MHz
  localparam int FLD_TSTEP_US = 30000;
  localparam int FLD_CLK_KHZ  = 50000;
  localparam int FLD_STEP_CYC = FLD_TSTEP_US * FLD_CLK_KHZ / 1000;
endpackage

// [core/fld_i2c_slave.sv]
`timescale 1ns/1ns
module fld_i2c_slave import fld_pkg::*; (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [7:0] rdata_i,
  output logic            sda_oe_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o
);
  typedef enum logic [3:0] {
    FLD_I_IDLE, FLD_I_ADDR, FLD_I_ACKA, FLD_I_REG, FLD_I_ACKR,
    FLD_I_WDAT, FLD_I_ACKW, FLD_I_RDAT, FLD_I_RACK
  } fld_i2c_e;

  typedef struct packed {
    logic       scl_m;
    logic       scl;
    logic       scl_p;
    logic       sda_m;
    logic       sda;
    logic       sda_p;
    fld_i2c_e   st;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic       rw;
    logic       nack;
    logic       drive;
    logic       wr;
    logic       rd;
  } fld_i2c_s;

  fld_i2c_s s;
  fld_i2c_s next_s;
  logic     rise;
  logic     fall;
  logic     start;
  logic     stop;

  assign rise  = s.scl & ~s.scl_p;
  assign fall  = ~s.scl & s.scl_p;
  assign start = s.scl & s.scl_p & s.sda_p & ~s.sda;
  assign stop  = s.scl & s.scl_p & ~s.sda_p & s.sda;

  always_comb begin
    next_s       = s;
    next_s.scl_m = scl_i;
    next_s.scl   = s.scl_m;
    next_s.scl_p = s.scl;
    next_s.sda_m = sda_i;
    next_s.sda   = s.sda_m;
    next_s.sda_p = s.sda;
    next_s.wr    = 1'b0;
    next_s.rd    = 1'b0;
    if (rise) begin
      next_s.bits = 4'(s.bits + 4'd1);
      if (s.st == FLD_I_ADDR || s.st == FLD_I_REG || s.st == FLD_I_WDAT) begin
        next_s.sh = {s.sh[6:0], s.sda};
      end
    end
    if (start) begin
      next_s.st    = FLD_I_ADDR;
      next_s.bits  = 4'h0;
      next_s.drive = 1'b0;
    end else if (stop) begin
      next_s.st    = FLD_I_IDLE;
      next_s.drive = 1'b0;
    end else begin
      case (s.st)
        FLD_I_ADDR: begin
          if (fall && s.bits == 4'h8) begin
            if (s.sh[7:1] == FLD_I2C_ADDR) begin
              next_s.rw    = s.sh[0];
              next_s.drive = 1'b1;
              next_s.st    = FLD_I_ACKA;
            end else begin
              next_s.st = FLD_I_IDLE;
            end
          end
        end
        FLD_I_ACKA, FLD_I_RACK: begin
          if (s.st == FLD_I_RACK && rise) begin
            next_s.nack = s.sda;
            if (!s.sda) begin
              next_s.ptr = 8'(s.ptr + 8'd1);
            end
          end
          if (fall) begin
            next_s.bits  = 4'h0;
            next_s.drive = 1'b0;
            if (s.st == FLD_I_RACK && s.nack) begin
              next_s.st = FLD_I_IDLE;
            end else if (s.rw) begin
              // Read data is taken from the live register image
              next_s.sh    = rdata_i;
              next_s.drive = ~rdata_i[7];
              next_s.rd    = 1'b1;
              next_s.st    = FLD_I_RDAT;
            end else begin
              next_s.st = FLD_I_REG;
            end
          end
        end
        FLD_I_REG: begin
          if (fall && s.bits == 4'h8) begin
            next_s.ptr   = s.sh;
            next_s.drive = 1'b1;
            next_s.st    = FLD_I_ACKR;
          end
        end
        FLD_I_WDAT: begin
          if (fall && s.bits == 4'h8) begin
            next_s.wr    = 1'b1;
            next_s.drive = 1'b1;
            next_s.st    = FLD_I_ACKW;
          end
        end
        FLD_I_ACKR, FLD_I_ACKW: begin
          if (fall) begin
            next_s.drive = 1'b0;
            next_s.bits  = 4'h0;
            next_s.st    = FLD_I_WDAT;
            if (s.st == FLD_I_ACKW) begin
              next_s.ptr = 8'(s.ptr + 8'd1);
            end
          end
        end
        FLD_I_RDAT: begin
          if (fall) begin
            if (s.bits == 4'h8) begin
              next_s.drive = 1'b0;
              next_s.st    = FLD_I_RACK;
            end else begin
              next_s.sh    = {s.sh[6:0], 1'b0};
              next_s.drive = ~s.sh[6];
            end
          end
        end
        default: next_s.st = FLD_I_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s       <= '0;
      s.scl_m <= 1'b1;
      s.scl   <= 1'b1;
      s.scl_p <= 1'b1;
      s.sda_m <= 1'b1;
      s.sda   <= 1'b1;
      s.sda_p <= 1'b1;
      s.st    <= FLD_I_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign sda_oe_o = s.drive;
  assign wr_o     = s.wr;
  assign rd_o     = s.rd;
  assign addr_o   = s.ptr;
  assign wdata_o  = s.sh;
endmodule

// [dv/fld_i2c_master.sv]
`timescale 1ns/1ns
module fld_i2c_master import fld_pkg::*; (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic start();
    sda_oe_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    sda_oe_o <= 1'b1;
    tick(2);
    scl_o <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_oe_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    sda_oe_o <= 1'b0;
    tick(6);
  endtask
  // Sampled on the edge that raises the clock
  task automatic bit_x(input logic b, output logic r);
    sda_oe_o <= ~b;
    tick(2);
    scl_o <= 1'b1;
    r = sda_i;
    tick(4);
    scl_o <= 1'b0;
    tick(2);
  endtask
  // MSB first, ninth bit is the ack
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(ai, ack);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [2:0] k;
    start();
    xfer({FLD_I2C_ADDR, 1'b0}, 1'b1, q, k[0]);
    xfer(a, 1'b1, q, k[1]);
    xfer(d, 1'b1, q, k[2]);
    stop();
    ok = (k === 3'b000);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [2:0] k;
    start();
    xfer({FLD_I2C_ADDR, 1'b0}, 1'b1, q, k[0]);
    xfer(a, 1'b1, q, k[1]);
    start();
    xfer({FLD_I2C_ADDR, 1'b1}, 1'b1, q, k[2]);
    xfer(8'hFF, 1'b1, d, q[0]);
    stop();
    ok = (k === 3'b000);
  endtask
endmodule

// [dv/flash_led_driver_control_bench.sv]
`timescale 1ns/1ns
module flash_led_driver_control_bench import fld_pkg::*;
;
  localparam int STEP = 20;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       strobe = 1'b0;
  logic       ovp = 1'b0;
  logic       shrt = 1'b0;
  logic       temp = 1'b0;
  logic       coil = 1'b0;
  logic       scl;
  logic       oe_m;
  logic       oe_d;
  logic       sda;
  logic       sda_o;
  logic       led_en;
  logic       boost_en;
  logic [1:0] led_level;
  logic [7:0] cur;
  int         error_cnt = 0;
  int         num_checks = 0;
  int         cyc = 0;
  // Open-drain line with pull-up
  assign sda = ~oe_m & (oe_d ? sda_o : 1'b1);
  initial begin
    forever #10 clk = ~clk;
  end
  fld_i2c_master mst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(oe_m));
  fld_ctrl #(.STEP_CYCLES(STEP)) uut (
    .CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(oe_d),
    .STROBE_I(strobe), .OVP_I(ovp), .LED_SHORT_I(shrt), .OVERTEMP_I(temp),
    .BOOST_INDUCTOR_OPEN_I(coil), .LED_EN_O(led_en), .BOOST_EN_O(boost_en),
    .LED_LEVEL_O(led_level), .CURRENT_SET_O(cur)
  );
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Long enough for every scenario with margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt = error_cnt + 1;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic outs(input logic [3:0] e);
    chk({4'h0, led_en, boost_en, led_level}, {4'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    mst.wr(a, d, ok);
    chk({7'h0, ok}, 8'h01);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic       ok;
    logic [7:0] q;
    mst.rd(a, q, ok);
    chk({7'h0, ok}, 8'h01);
    chk(q, e);
  endtask
  task automatic wait_led(input logic lvl, input int lim, output int n);
    n = 0;
    while (led_en !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic t_reset();
    outs(4'h0);
    chk(cur, FLD_CUR_RST);
    rdc(FLD_ADR_CUR, FLD_CUR_RST);
    rdc(FLD_ADR_CTL, FLD_CTL_RST);
    rdc(FLD_ADR_FLT, FLD_FLT_RST);
  endtask
  task automatic t_selftest();
    wr(FLD_ADR_CTL, FLD_CTL_ASSIST);
    outs(4'hE);
    rdc(FLD_ADR_CTL, FLD_CTL_ASSIST);
    wr(FLD_ADR_CTL, FLD_CTL_OFF);
    outs(4'h0);
    rdc(FLD_ADR_FLT, 8'h00);
  endtask
  task automatic t_faults();
    logic [7:0] exp [3] = '{8'h80, 8'h40, 8'h20};
    for (int i = 0; i < 3; i++) begin
      wr(FLD_ADR_CTL, FLD_CTL_ASSIST);
      {ovp, shrt, temp} <= 3'b100 >> i;
      repeat (8) @(posedge clk);
      outs(4'h0);
      {ovp, shrt, temp} <= 3'b000;
      rdc(FLD_ADR_FLT, exp[i]);
      rdc(FLD_ADR_FLT, 8'h00);
    end
  endtask
  task automatic t_coil();
    wr(FLD_ADR_CTL, FLD_CTL_ASSIST);
    coil <= 1'b1;
    repeat (8) @(posedge clk);
    outs(4'h0);
    coil <= 1'b0;
    rdc(FLD_ADR_CTL, 8'h00);
    rdc(FLD_ADR_FLT, 8'h00);
  endtask
  task automatic t_unlock();
    wr(FLD_ADR_CUR, FLD_CUR_MAX);
    chk(cur, FLD_CUR_RST);
    wr(FLD_ADR_KEY, FLD_KEY);
    wr(FLD_ADR_CTL, FLD_CTL_OFF);
    wr(FLD_ADR_CUR, FLD_CUR_MAX);
    chk(cur, FLD_CUR_RST);
    wr(FLD_ADR_KEY, FLD_KEY);
    wr(FLD_ADR_CUR, FLD_CUR_MAX);
    chk(cur, FLD_CUR_MAX);
    rdc(FLD_ADR_CUR, FLD_CUR_MAX);
    // Indicator mode is protected as well and runs without boost
    wr(FLD_ADR_CTL, 8'h10);
    outs(4'h0);
    wr(FLD_ADR_KEY, FLD_KEY);
    wr(FLD_ADR_CTL, 8'h10);
    outs(4'h9);
    wr(FLD_ADR_CTL, FLD_CTL_OFF);
    outs(4'h0);
  endtask
  task automatic t_flash();
    int n;
    wr(FLD_ADR_CTL, FLD_CTL_FLASH);
    outs(4'hF);
    wait_led(1'b0, 1000, n);
    // Write tail already used part of the 16 steps
    chk({7'h0, n >= 16 * STEP - 35 && n <= 16 * STEP}, 8'h01);
    outs(4'h0);
    rdc(FLD_ADR_CTL, 8'h0F);
  endtask
  task automatic t_strobe();
    int n;
    wr(FLD_ADR_KEY, FLD_KEY);
    wr(FLD_ADR_CTL, 8'hB1);
    repeat (40) @(posedge clk);
    outs(4'h0);
    strobe <= 1'b1;
    wait_led(1'b1, 20, n);
    chk({7'h0, n <= 8}, 8'h01);
    strobe <= 1'b0;
    wait_led(1'b0, 200, n);
    chk({7'h0, n >= 2 * STEP - 3 && n <= 2 * STEP + 1}, 8'h01);
  endtask
  task automatic t_abort();
    int n;
    wr(FLD_ADR_KEY, FLD_KEY);
    wr(FLD_ADR_CTL, 8'hBF);
    strobe <= 1'b1;
    wait_led(1'b1, 20, n);
    strobe <= 1'b0;
    outs(4'hF);
    // Flash would run longer than this write
    wr(FLD_ADR_CTL, FLD_CTL_OFF);
    outs(4'h0);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_selftest();
    t_faults();
    t_coil();
    t_unlock();
    t_flash();
    t_strobe();
    t_abort();
    conclude();
  end
endmodule
